/* File: src/aux_pkg.sv */
// aux_pkg: offsets, field positions and reset values of the auxiliary
// pin block.
// assumes a 32-bit axi4-lite slave with word-aligned registers.
package aux_pkg;

  localparam int AUX_NPINS = 3;
  localparam int AUX_ADDR_W = 12;

  // printed register indexes; byte address is four times the index
  localparam logic [7:0] AUX_CFG2_IDX = 8'h59;
  localparam logic [7:0] AUX_CFG34_IDX = 8'h5a;
  localparam logic [11:0] AUX_CFG2_ADDR = {2'h0, AUX_CFG2_IDX, 2'h0};
  localparam logic [11:0] AUX_CFG34_ADDR = {2'h0, AUX_CFG34_IDX, 2'h0};
  localparam logic [11:0] AUX_STATUS_ADDR = 12'h200;
  localparam logic [11:0] AUX_IRQ_STAT_ADDR = 12'h204;
  localparam logic [11:0] AUX_IRQ_MASK_ADDR = 12'h208;

  // field positions inside one pin's nibble
  localparam int AUX_FLD_DIR = 0;
  localparam int AUX_FLD_POL = 1;
  localparam int AUX_FLD_EDGE = 2;
  localparam int AUX_FLD_OUT = 3;

  // nibble positions: pin 2 in upper half of cfg2, pins 3/4 in cfg34
  localparam int AUX_PIN2_LSB = 4;
  localparam int AUX_PIN3_LSB = 0;
  localparam int AUX_PIN4_LSB = 4;

  // values after power-on; suspend entry reloads the pin configs but not the mask
  localparam logic [3:0] AUX_RST_PIN2 = 4'h0;
  localparam logic [7:0] AUX_RST_CFG34 = 8'h90;
  localparam logic [2:0] AUX_RST_MASK = 3'h0;

  localparam logic [1:0] AUX_RESP_OKAY = 2'h0;
  localparam logic [1:0] AUX_RESP_SLVERR = 2'h2;

endpackage : aux_pkg

/* File: src/aux_chan_if.sv */
// aux_chan_if: configuration and status of one auxiliary pin.
// assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface aux_chan_if;
  logic [3:0] cfg;
  logic rd_clr;
  logic state;
  logic pin_out;
  logic pin_oe;

  modport ctl (output cfg, output rd_clr, input state, input pin_out,
    input pin_oe);
  modport chan (input cfg, input rd_clr, output state, output pin_out,
    output pin_oe);
endinterface : aux_chan_if
`default_nettype wire

/* File: src/aux_pin_chan.sv */
// aux_pin_chan: one auxiliary pin: synchroniser, polarity, level or
// latched edge status, output drive.
// assumes pin_raw is asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module aux_pin_chan (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_raw,
  aux_chan_if.chan ch
);

  logic sync1_reg;
  logic sync2_reg;
  logic latch_reg;
  logic pin_true;

  // two flops before any logic looks at the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // polarity picks the true level
  assign pin_true = ch.cfg[aux_pkg::AUX_FLD_POL] ? sync2_reg : ~sync2_reg;

  // latch: a true level in the clearing cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= 1'b0;
    end else if (pin_true) begin
      latch_reg <= 1'b1;
    end else if (ch.rd_clr) begin
      latch_reg <= 1'b0;
    end
  end

  // level or latched report
  assign ch.state = ch.cfg[aux_pkg::AUX_FLD_EDGE] ? latch_reg : pin_true;

  // direction and driven level
  assign ch.pin_oe = ch.cfg[aux_pkg::AUX_FLD_DIR];
  assign ch.pin_out = ch.cfg[aux_pkg::AUX_FLD_OUT];

endmodule : aux_pin_chan
`default_nettype wire

/* File: src/aux_pin_config_status.sv */
// aux_pin_config_status: axi4-lite register file and three auxiliary
// pins (2, 3, 4) with status and interrupt.
// assumes pins and usb_suspend are asynchronous; one clock aclk.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module aux_pin_config_status #(
  parameter int ADDR_W = aux_pkg::AUX_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_suspend,
  input wire logic [2:0] aux_in,
  output logic [2:0] aux_out,
  output logic [2:0] aux_oe,
  output logic irq
);

  // refused at elaboration: the decode needs all twelve address bits
  if (ADDR_W < aux_pkg::AUX_ADDR_W) begin : g_addr_w_bad
    $error("ADDR_W too small for the register map");
  end

  // config and interrupt state
  logic [3:0] cfg2_reg;
  logic [7:0] cfg34_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] state_prev_reg;
  logic [2:0] state_now;
  logic [2:0] state_rise;

  // suspend synchroniser and entry detect
  logic susp1_reg;
  logic susp2_reg;
  logic susp3_reg;
  logic susp_enter;

  // write channel
  logic aw_held_reg;
  logic [11:0] awaddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic do_write;

  // read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_take;
  logic [11:0] rd_addr;
  logic status_rd;

  aux_chan_if ch [aux_pkg::AUX_NPINS] ();

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == aux_pkg::AUX_CFG2_ADDR) ||
      (a == aux_pkg::AUX_CFG34_ADDR) ||
      (a == aux_pkg::AUX_STATUS_ADDR) ||
      (a == aux_pkg::AUX_IRQ_STAT_ADDR) ||
      (a == aux_pkg::AUX_IRQ_MASK_ADDR);
  endfunction : addr_hit

  function automatic logic [31:0] rd_mux(input logic [11:0] a,
      input logic [3:0] c2, input logic [7:0] c34, input logic [2:0] st,
      input logic [2:0] is, input logic [2:0] im);
    rd_mux = 32'h0;
    unique case (a)
      aux_pkg::AUX_CFG2_ADDR: rd_mux = {24'h0, c2, 4'h0};
      aux_pkg::AUX_CFG34_ADDR: rd_mux = {24'h0, c34};
      aux_pkg::AUX_STATUS_ADDR: rd_mux = {29'h0, st};
      aux_pkg::AUX_IRQ_STAT_ADDR: rd_mux = {29'h0, is};
      aux_pkg::AUX_IRQ_MASK_ADDR: rd_mux = {29'h0, im};
      default: rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  // pin channels: index 0 is pin 2, 1 is pin 3, 2 is pin 4
  assign ch[0].cfg = cfg2_reg;
  assign ch[1].cfg = cfg34_reg[aux_pkg::AUX_PIN3_LSB +: 4];
  assign ch[2].cfg = cfg34_reg[aux_pkg::AUX_PIN4_LSB +: 4];

  for (genvar i = 0; i < aux_pkg::AUX_NPINS; i++) begin : g_pin
    assign ch[i].rd_clr = status_rd;
    assign state_now[i] = ch[i].state;
    assign aux_out[i] = ch[i].pin_out;
    assign aux_oe[i] = ch[i].pin_oe;
    aux_pin_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_raw(aux_in[i]),
      .ch(ch[i])
    );
  end

  // suspend is a pin from the usb core's domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp1_reg <= 1'b0;
      susp2_reg <= 1'b0;
      susp3_reg <= 1'b0;
    end else begin
      susp1_reg <= usb_suspend;
      susp2_reg <= susp1_reg;
      susp3_reg <= susp2_reg;
    end
  end

  assign susp_enter = susp2_reg & ~susp3_reg;

  // axi write: address and data taken in either order
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 12'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= {s_axi_awaddr[11:2], 2'h0};
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= aux_pkg::AUX_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_hit(awaddr_reg) ? aux_pkg::AUX_RESP_OKAY :
        aux_pkg::AUX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // config: suspend entry beats a write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || susp_enter) begin
      cfg2_reg <= aux_pkg::AUX_RST_PIN2;
      cfg34_reg <= aux_pkg::AUX_RST_CFG34;
    end else if (do_write && wstrb0_reg) begin
      if (awaddr_reg == aux_pkg::AUX_CFG2_ADDR) begin
        cfg2_reg <= wdata_reg[aux_pkg::AUX_PIN2_LSB +: 4];
      end
      if (awaddr_reg == aux_pkg::AUX_CFG34_ADDR) begin
        cfg34_reg <= wdata_reg[7:0];
      end
    end
  end

  // irq: a rising state bit sets a sticky flag; set beats w1c
  assign state_rise = state_now & ~state_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_prev_reg <= 3'h0;
    end else begin
      state_prev_reg <= state_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 3'h0;
    end else if (do_write && wstrb0_reg &&
        awaddr_reg == aux_pkg::AUX_IRQ_STAT_ADDR) begin
      irq_stat_reg <= (irq_stat_reg & ~wdata_reg[2:0]) | state_rise;
    end else begin
      irq_stat_reg <= irq_stat_reg | state_rise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= aux_pkg::AUX_RST_MASK;
    end else if (do_write && wstrb0_reg &&
        awaddr_reg == aux_pkg::AUX_IRQ_MASK_ADDR) begin
      irq_mask_reg <= wdata_reg[2:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // axi read: one cycle to data; status read clears latches
  assign s_axi_arready = ~rvalid_reg;
  assign rd_take = s_axi_arvalid & ~rvalid_reg;
  assign rd_addr = {s_axi_araddr[11:2], 2'h0};
  assign status_rd = rd_take & (rd_addr == aux_pkg::AUX_STATUS_ADDR);
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= aux_pkg::AUX_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux(rd_addr, cfg2_reg, cfg34_reg, state_now,
        irq_stat_reg, irq_mask_reg);
      rresp_reg <= addr_hit(rd_addr) ? aux_pkg::AUX_RESP_OKAY :
        aux_pkg::AUX_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : aux_pin_config_status
`default_nettype wire

/* File: dv/aux_chk.sv */
// aux_chk: bus and pin assertions on the top ports.
// assumes a bind onto aux_pin_config_status, one clock.
`timescale 1ns/100ps
`default_nettype none
module aux_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic usb_suspend,
  input wire logic [2:0] aux_oe,
  input wire logic [2:0] aux_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h300;
  endsequence
  sequence s_rd_err;
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endsequence
  // pin drive moves only on a write or a suspend entry
  property p_src(logic [2:0] v);
    $changed(v) |-> $rose(s_axi_bvalid) || $past(usb_suspend, 2) ||
      $past(usb_suspend, 3) || $past(usb_suspend, 4);
  endproperty
  AST_RST_PINS: assert property (
    $rose(aresetn) |-> aux_oe == 3'h4 && aux_out[2])
    else $error("pin defaults wrong after reset");
  AST_SUSP: assert property (
    $rose(usb_suspend) |-> ##[2:4] (aux_oe == 3'h4 && aux_out[2]))
    else $error("pin defaults missing after suspend");
  AST_OE_SRC: assert property (p_src(aux_oe))
    else $error("direction changed without cause");
  AST_OUT_SRC: assert property (p_src(aux_out))
    else $error("output level changed without cause");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AW_BLK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  AST_RD_ERR: assert property (s_rd_bad |=> s_rd_err)
    else $error("unmapped read not refused");
endmodule : aux_chk
`default_nettype wire

/* File: dv/aux_board.sv */
// aux_board: board levels on the three auxiliary pins.
// assumes the board always drives an undriven pin.
`timescale 1ns/100ps
`default_nettype none
module aux_board (
  input wire logic [2:0] aux_out,
  input wire logic [2:0] aux_oe,
  input wire logic [2:0] drive,
  output logic [2:0] pin
);
  // a driven pin shows the device level
  assign pin = (aux_oe & aux_out) | (~aux_oe & drive);
endmodule : aux_board
`default_nettype wire

/* File: dv/tb.sv */
// tb: register, pin, interrupt and suspend scenarios.
// assumes aux_board on the pins and an axi4-lite master here.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [11:0] A2 = aux_pkg::AUX_CFG2_ADDR;
  localparam logic [11:0] A34 = aux_pkg::AUX_CFG34_ADDR;
  localparam logic [11:0] AS = aux_pkg::AUX_STATUS_ADDR;
  localparam logic [11:0] AI = aux_pkg::AUX_IRQ_STAT_ADDR;
  localparam logic [11:0] AM = aux_pkg::AUX_IRQ_MASK_ADDR;
  logic aclk = 1'h0, aresetn = 1'h0, usb_suspend = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [2:0] aux_in, aux_out, aux_oe, drive = 3'h0;
  int fail_count = 0, checked = 0, cyc = 0;
  aux_pin_config_status u_aux_pin_config_status (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .usb_suspend, .aux_in, .aux_out, .aux_oe, .irq);
  aux_board u_aux_board (.aux_out, .aux_oe, .drive, .pin(aux_in));
  initial forever #4 aclk = ~aclk;
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // handshakes judged at the rising edge, before that edge's updates land
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic bv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
    end while (!bv);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!tv);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wo(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(32'h0, r);
  endtask : wo
  task automatic ro(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(e, d);
  endtask : ro
  // two sync flops, the latch and the irq flag each take one edge
  task automatic pins(input logic [2:0] v);
    drive <= v;
    repeat (5) @(posedge aclk);
  endtask : pins
  task automatic t_reset;
    ro(A2, 32'h0);
    ro(A34, 32'h90);
    ro(AM, 32'h0);
    chk(32'h4, aux_oe);
    chk(32'h4, aux_out);
    $display("test reset done");
  endtask : t_reset
  task automatic t_out;
    wo(A2, 32'h90);
    wo(A34, 32'h19);
    chk(32'h7, aux_oe);
    chk(32'h3, aux_out);
    wo(A2, 32'h10);
    wo(A34, 32'h91);
    chk(32'h4, aux_out);
    ro(A34, 32'h91);
    $display("test output done");
  endtask : t_out
  task automatic t_level;
    wo(A2, 32'h20);
    wo(A34, 32'h22);
    pins(3'h5);
    ro(AS, 32'h5);
    pins(3'h2);
    ro(AS, 32'h2);
    wo(A2, 32'h0);
    wo(A34, 32'h0);
    ro(AS, 32'h5);
    $display("test level done");
  endtask : t_level
  task automatic t_edge;
    logic [31:0] d;
    logic [1:0] r;
    wo(A2, 32'h60);
    wo(A34, 32'h66);
    pins(3'h0);
    rd(AS, d, r);
    ro(AS, 32'h0);
    pins(3'h7);
    pins(3'h0);
    ro(AS, 32'h7);
    ro(AS, 32'h0);
    $display("test edge done");
  endtask : t_edge
  task automatic t_irq;
    wo(AI, 32'h7);
    ro(AI, 32'h0);
    wo(AM, 32'h7);
    chk(32'h0, irq);
    pins(3'h1);
    chk(32'h1, irq);
    ro(AI, 32'h1);
    wo(AM, 32'h0);
    chk(32'h0, irq);
    wo(AM, 32'h7);
    chk(32'h1, irq);
    wo(AI, 32'h1);
    chk(32'h0, irq);
    $display("test irq done");
  endtask : t_irq
  task automatic t_bad;
    logic [31:0] d;
    logic [1:0] r;
    wr(12'h300, 32'h1, r);
    chk(32'h2, r);
    rd(12'h300, d, r);
    chk(32'h2, r);
    chk(32'h0, d);
    s_axi_wstrb <= 4'h0;
    wo(A34, 32'h0);
    s_axi_wstrb <= 4'hf;
    ro(A34, 32'h66);
    $display("test unmapped done");
  endtask : t_bad
  task automatic t_susp;
    wo(A2, 32'h90);
    wo(A34, 32'h11);
    usb_suspend <= 1'h1;
    repeat (6) @(posedge aclk);
    chk(32'h4, aux_oe);
    chk(32'h4, aux_out);
    usb_suspend <= 1'h0;
    ro(A2, 32'h0);
    ro(A34, 32'h90);
    $display("test suspend done");
  endtask : t_susp
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      conclude;
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_out;
    t_level;
    t_edge;
    t_irq;
    t_bad;
    t_susp;
    conclude;
  end
endmodule : tb
bind aux_pin_config_status aux_chk u_aux_chk (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .usb_suspend, .aux_oe, .aux_out);
`default_nettype wire
